// [verilog/alc_pkg.sv]
package alc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int AMP_W   = 12;
	localparam int SHUT_W  = 24;
	localparam int PIX_W   = 12;
	localparam int COORD_W = 12;
	localparam int CNT_W   = 22;
	localparam int SUM_W   = 30;
	localparam int ADDR_W  = 8;

	// ----------------------------------------
	// Loop modes
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		MODE_OFF  = 2'b00,
		MODE_ONCE = 2'b01,
		MODE_CONT = 2'b10
	} loop_mode_t;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TARGET     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_AMP_LIM    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SHUT_FLOOR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_SHUT_CEIL  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_AMP_MAN    = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SHUT_MAN   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATS_X    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STATS_Y    = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IMAGE_X    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_IMAGE_Y    = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_AMP_NOW    = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_SHUT_NOW   = 8'h34;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_AMP_LSB  = 0;
	localparam int CTRL_SHUT_LSB = 2;
	localparam int CTRL_PRIO_BIT = 4;
	localparam int HI_LSB        = 16;
	localparam int ST_AMP_BIT    = 0;
	localparam int ST_SHUT_BIT   = 1;
	localparam int ST_DARK_BIT   = 2;
	localparam int ST_BRIGHT_BIT = 3;
	localparam int ST_EMPTY_BIT  = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]         TARGET_RST     = 8'h80;
	localparam logic [AMP_W-1:0]   AMP_FLOOR_RST  = 12'h000;
	localparam logic [AMP_W-1:0]   AMP_CEIL_RST   = 12'hFFF;
	localparam logic [AMP_W-1:0]   AMP_MAN_RST    = 12'h040;
	localparam logic [SHUT_W-1:0]  SHUT_FLOOR_RST = 24'h000000;
	localparam logic [SHUT_W-1:0]  SHUT_CEIL_RST  = 24'hFFFFFF;
	localparam logic [SHUT_W-1:0]  SHUT_MAN_RST   = 24'h002710;
	localparam logic [COORD_W-1:0] WIN_OFS_RST    = 12'h000;
	localparam logic [COORD_W-1:0] WIN_LEN_RST    = 12'hFFF;

	// ----------------------------------------
	// Device bounds and steps
	// ----------------------------------------
	localparam logic [AMP_W-1:0]  AMP_MIN_NARROW = 12'h040;
	localparam logic [AMP_W-1:0]  AMP_MIN_WIDE   = 12'h020;
	localparam logic [AMP_W-1:0]  AMP_MIN_BIN    = 12'h000;
	localparam logic [AMP_W-1:0]  AMP_MAX_STD    = 12'h3FF;
	localparam logic [AMP_W-1:0]  AMP_MAX_EXT    = 12'hFFF;
	localparam logic [SHUT_W-1:0] SHUT_MIN       = 24'h000014;
	localparam logic [SHUT_W-1:0] SHUT_MAX       = 24'hF42400;
	localparam logic [AMP_W-1:0]  AMP_STEP       = 12'h004;
	localparam logic [SHUT_W-1:0] SHUT_STEP      = 24'h000010;
	localparam logic [4:0]        ONCE_MAX_FRAMES = 5'h1E;

endpackage : alc_pkg

// [verilog/lim_bound.sv]
`timescale 1ns/10ps
module lim_bound
#(
	parameter int W = 12
)
(
	input  wire logic [W-1:0] req_lo,
	input  wire logic [W-1:0] req_hi,
	input  wire logic [W-1:0] dev_lo,
	input  wire logic [W-1:0] dev_hi,
	output logic      [W-1:0] eff_lo,
	output logic      [W-1:0] eff_hi
);

	logic [W-1:0] lo_a;
	logic [W-1:0] hi_a;

	// ----------------------------------------
	// Programmed limits kept inside device range
	// ----------------------------------------
	always_comb
	begin
		lo_a = (req_lo > dev_lo) ? req_lo : dev_lo;
		if (lo_a > dev_hi)
			lo_a = dev_hi;
		hi_a = (req_hi < dev_hi) ? req_hi : dev_hi;
		// Crossed limits collapse onto the floor
		if (hi_a < lo_a)
			hi_a = lo_a;
		eff_lo = lo_a;
		eff_hi = hi_a;
	end

endmodule : lim_bound

// [verilog/win_stats.sv]
`timescale 1ns/10ps
module win_stats
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        frame_start,
	input  wire logic                        frame_end,
	input  wire logic                        pix_valid,
	input  wire logic [alc_pkg::COORD_W-1:0] pix_x,
	input  wire logic [alc_pkg::COORD_W-1:0] pix_y,
	input  wire logic [alc_pkg::PIX_W-1:0]   pix_data,
	input  wire logic                        pix_wide,
	input  wire logic [4*alc_pkg::COORD_W-1:0] stats_win,
	input  wire logic [4*alc_pkg::COORD_W-1:0] image_win,
	output logic      [alc_pkg::SUM_W-1:0]   sum_r,
	output logic      [alc_pkg::CNT_W-1:0]   count_r,
	output logic                             done_r
);

	localparam int CW = alc_pkg::COORD_W;

	logic [alc_pkg::SUM_W-1:0] acc_sum_r;
	logic [alc_pkg::CNT_W-1:0] acc_cnt_r;
	logic [7:0]                pix_8;
	logic                      in_stats;
	logic                      in_image;

	// Window packing: x offset, width, y offset, height
	function automatic logic in_win(input logic [4*CW-1:0] w,
		input logic [CW-1:0] x, input logic [CW-1:0] y);
		logic [CW:0] xe;
		logic [CW:0] ye;
		xe = {1'b0, w[4*CW-1:3*CW]} + {1'b0, w[3*CW-1:2*CW]};
		ye = {1'b0, w[2*CW-1:CW]} + {1'b0, w[CW-1:0]};
		in_win = (x >= w[4*CW-1:3*CW]) && ({1'b0, x} < xe) &&
			(y >= w[2*CW-1:CW]) && ({1'b0, y} < ye);
	endfunction : in_win

	assign in_stats = in_win(stats_win, pix_x, pix_y);
	assign in_image = in_win(image_win, pix_x, pix_y);
	assign pix_8    = pix_wide ? pix_data[11:4] : pix_data[7:0]; // [R19]

	// ----------------------------------------
	// Accumulate overlap pixels only
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			acc_sum_r <= '0;
			acc_cnt_r <= '0;
		end
		else if (frame_start)
		begin
			acc_sum_r <= '0;
			acc_cnt_r <= '0;
		end
		else if (pix_valid && in_stats && in_image) // [R18]
		begin
			acc_sum_r <= acc_sum_r + {22'h000000, pix_8};
			acc_cnt_r <= acc_cnt_r + 22'h000001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sum_r   <= '0;
			count_r <= '0;
			done_r  <= 1'b0;
		end
		else
		begin
			done_r <= frame_end;
			if (frame_end)
			begin
				sum_r   <= acc_sum_r;
				count_r <= acc_cnt_r;
			end
		end
	end

endmodule : win_stats

// [verilog/auto_luminance_control.sv]
// Behaviour
// [R01] Gain steps toward target within gain limits
// [R02] Window one statistics; once and continuous modes
// [R03] No overlap: manual gain sets brightness
// [R04] Gain range follows format, binning, limit removal
// [R05] Target is eight bits, black 0, white 255
// [R06] Wide pixel output still uses 0..255 target
// [R07] Exposure steps toward target within exposure limits
// [R08] Exposure not tied to manual time base
// [R09] No overlap: manual exposure sets brightness
// [R10] Trigger-width mode disables automatic exposure
// [R11] Software sets priority, both loops continuous
// [R12] Exposure limits bounded by device min/max
// [R13] Long exposures may lower frame rate
// [R14] Software sets window, limits, target, then mode
// [R15] Once mode gives up after 30 images
// [R16] Switched off loop keeps last value
// [R17] Priority picks which setting stays low
// [R18] Only overlapping window pixels counted
// [R19] Wide pixels scaled to eight bits
`timescale 1ns/10ps
module auto_luminance_control
(
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic                             hreadyout,
	output logic [31:0]                      hrdata,
	output logic                             hresp,
	input  wire logic                        frame_start,
	input  wire logic                        frame_end,
	input  wire logic                        pix_valid,
	input  wire logic [alc_pkg::COORD_W-1:0] pix_x,
	input  wire logic [alc_pkg::COORD_W-1:0] pix_y,
	input  wire logic [alc_pkg::PIX_W-1:0]   pix_data,
	input  wire logic                        pix_wide,
	input  wire logic                        binning_on,
	input  wire logic                        amp_limits_removed,
	input  wire logic                        trigger_width_mode,
	output logic [alc_pkg::AMP_W-1:0]        amp_now_r,
	output logic [alc_pkg::SHUT_W-1:0]       shutter_now_r
);

	localparam int AW = alc_pkg::AMP_W;
	localparam int SW = alc_pkg::SHUT_W;
	localparam int CW = alc_pkg::COORD_W;
	localparam int SUM_W_X = alc_pkg::SUM_W + 1;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	alc_pkg::loop_mode_t amp_loop_mode_r;
	alc_pkg::loop_mode_t shutter_loop_mode_r;
	logic                loop_priority_r;
	logic [7:0]          brightness_target_r;
	logic [AW-1:0]       amp_floor_r;
	logic [AW-1:0]       amp_ceiling_r;
	logic [SW-1:0]       shutter_floor_r;
	logic [SW-1:0]       shutter_ceiling_r;
	logic [AW-1:0]       amp_manual_r;
	logic [SW-1:0]       shutter_manual_r;
	logic [4*CW-1:0]     stats_window_one_r;
	logic [4*CW-1:0]     image_win_r;
	logic [4:0]          amp_tries_r;
	logic [4:0]          shut_tries_r;
	logic                last_dark_r;
	logic                last_bright_r;
	logic                last_empty_r;
	logic [alc_pkg::ADDR_W-1:0] addr_r;
	logic                wr_r;
	logic                rd_r;

	logic [alc_pkg::SUM_W-1:0] sum;
	logic [alc_pkg::CNT_W-1:0] count;
	logic                      done;
	logic [AW-1:0]             amp_lo;
	logic [AW-1:0]             amp_hi;
	logic [SW-1:0]             shut_lo;
	logic [SW-1:0]             shut_hi;
	logic [AW-1:0]             amp_dev_lo;
	logic [AW-1:0]             amp_dev_hi;

	// ----------------------------------------
	// Statistics and limit bounding
	// ----------------------------------------
	win_stats u_stats
	(
		.hclk        (hclk),
		.hresetn     (hresetn),
		.frame_start (frame_start),
		.frame_end   (frame_end),
		.pix_valid   (pix_valid),
		.pix_x       (pix_x),
		.pix_y       (pix_y),
		.pix_data    (pix_data),
		.pix_wide    (pix_wide),
		.stats_win   (stats_window_one_r), // [R02]
		.image_win   (image_win_r),
		.sum_r       (sum),
		.count_r     (count),
		.done_r      (done)
	);

	assign amp_dev_lo = binning_on ? alc_pkg::AMP_MIN_BIN :
		(pix_wide ? alc_pkg::AMP_MIN_WIDE : alc_pkg::AMP_MIN_NARROW); // [R04]
	assign amp_dev_hi = amp_limits_removed ? alc_pkg::AMP_MAX_EXT : alc_pkg::AMP_MAX_STD; // [R04]

	lim_bound #(.W(AW)) u_amp_lim
	(
		.req_lo (amp_floor_r),
		.req_hi (amp_ceiling_r),
		.dev_lo (amp_dev_lo),
		.dev_hi (amp_dev_hi),
		.eff_lo (amp_lo),
		.eff_hi (amp_hi)
	);

	// Frame rate is not checked: a long ceiling may slow the frame rate
	lim_bound #(.W(SW)) u_shut_lim
	(
		.req_lo (shutter_floor_r),
		.req_hi (shutter_ceiling_r),
		.dev_lo (alc_pkg::SHUT_MIN), // [R12]
		.dev_hi (alc_pkg::SHUT_MAX), // [R12] [R13]
		.eff_lo (shut_lo),
		.eff_hi (shut_hi)
	);

	// ----------------------------------------
	// Per-frame decision
	// ----------------------------------------
	logic                dark;
	logic                bright;
	logic                empty;
	logic                amp_run;
	logic                shut_run;
	logic                amp_first;
	logic                amp_blk;
	logic                shut_blk;
	logic                amp_move;
	logic                shut_move;
	logic [AW-1:0]       amp_step_val;
	logic [SW-1:0]       shut_step_val;
	logic [SUM_W_X-1:0]  goal_lo;
	logic [SUM_W_X-1:0]  goal_hi;

	always_comb
	begin
		goal_lo  = {1'b0, brightness_target_r} * {9'h000, count}; // [R05] [R06]
		goal_hi  = goal_lo + {9'h000, count};
		empty    = (count == '0);
		dark     = !empty && ({1'b0, sum} < goal_lo);
		bright   = !empty && ({1'b0, sum} >= goal_hi);
		amp_run  = amp_loop_mode_r != alc_pkg::MODE_OFF;
		shut_run = (shutter_loop_mode_r != alc_pkg::MODE_OFF) && !trigger_width_mode; // [R10]
		amp_blk  = !amp_run || (dark ? (amp_now_r >= amp_hi) : (amp_now_r <= amp_lo));
		shut_blk = !shut_run ||
			(dark ? (shutter_now_r >= shut_hi) : (shutter_now_r <= shut_lo));
		// Gain-minimum priority raises exposure first and lowers gain first
		amp_first = amp_run && (!shut_run || (dark ? loop_priority_r : !loop_priority_r)); // [R17]
		amp_move  = amp_run && (dark || bright) && (amp_first || shut_blk);
		shut_move = shut_run && (dark || bright) && (!amp_first || amp_blk);
		amp_step_val  = step(amp_now_r, dark, amp_lo, amp_hi);
		shut_step_val = step_s(shutter_now_r, dark, shut_lo, shut_hi);
	end

	function automatic logic [AW-1:0] step(input logic [AW-1:0] v, input logic up,
		input logic [AW-1:0] lo, input logic [AW-1:0] hi);
		logic [AW-1:0] r;
		if (up)
			r = (v >= hi || hi - v <= alc_pkg::AMP_STEP) ? hi : v + alc_pkg::AMP_STEP;
		else
			r = (v <= lo || v - lo <= alc_pkg::AMP_STEP) ? lo : v - alc_pkg::AMP_STEP;
		step = r;
	endfunction : step

	// Exposure moves in plain units, no time-base rounding
	function automatic logic [SW-1:0] step_s(input logic [SW-1:0] v, input logic up,
		input logic [SW-1:0] lo, input logic [SW-1:0] hi);
		logic [SW-1:0] r;
		if (up)
			r = (v >= hi || hi - v <= alc_pkg::SHUT_STEP) ? hi : v + alc_pkg::SHUT_STEP;
		else
			r = (v <= lo || v - lo <= alc_pkg::SHUT_STEP) ? lo : v - alc_pkg::SHUT_STEP;
		step_s = r; // [R08]
	endfunction : step_s

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	logic sel_ok;
	assign sel_ok = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_r    <= '0;
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_r <= sel_ok && hwrite;
			// Reads take one wait state so a prior write is visible
			rd_r      <= sel_ok && !hwrite;
			hreadyout <= !(sel_ok && !hwrite);
			if (sel_ok)
				addr_r <= haddr[alc_pkg::ADDR_W-1:0];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (rd_r)
		begin
			case (addr_r)
				alc_pkg::OFS_CTRL:       hrdata <= {27'h0000000, loop_priority_r,
					shutter_loop_mode_r, amp_loop_mode_r};
				alc_pkg::OFS_TARGET:     hrdata <= {24'h000000, brightness_target_r};
				alc_pkg::OFS_AMP_LIM:    hrdata <= {4'h0, amp_ceiling_r, 4'h0, amp_floor_r};
				alc_pkg::OFS_SHUT_FLOOR: hrdata <= {8'h00, shutter_floor_r};
				alc_pkg::OFS_SHUT_CEIL:  hrdata <= {8'h00, shutter_ceiling_r};
				alc_pkg::OFS_AMP_MAN:    hrdata <= {20'h00000, amp_manual_r};
				alc_pkg::OFS_SHUT_MAN:   hrdata <= {8'h00, shutter_manual_r};
				alc_pkg::OFS_STATS_X:    hrdata <= {4'h0, stats_window_one_r[3*CW-1:2*CW],
					4'h0, stats_window_one_r[4*CW-1:3*CW]};
				alc_pkg::OFS_STATS_Y:    hrdata <= {4'h0, stats_window_one_r[CW-1:0],
					4'h0, stats_window_one_r[2*CW-1:CW]};
				alc_pkg::OFS_IMAGE_X:    hrdata <= {4'h0, image_win_r[3*CW-1:2*CW],
					4'h0, image_win_r[4*CW-1:3*CW]};
				alc_pkg::OFS_IMAGE_Y:    hrdata <= {4'h0, image_win_r[CW-1:0],
					4'h0, image_win_r[2*CW-1:CW]};
				alc_pkg::OFS_STATUS:     hrdata <= {27'h0000000, last_empty_r, last_bright_r,
					last_dark_r, shut_run, amp_run};
				alc_pkg::OFS_AMP_NOW:    hrdata <= {20'h00000, amp_now_r};
				alc_pkg::OFS_SHUT_NOW:   hrdata <= {8'h00, shutter_now_r};
				default:                 hrdata <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			brightness_target_r <= alc_pkg::TARGET_RST;
			amp_floor_r         <= alc_pkg::AMP_FLOOR_RST;
			amp_ceiling_r       <= alc_pkg::AMP_CEIL_RST;
			shutter_floor_r     <= alc_pkg::SHUT_FLOOR_RST;
			shutter_ceiling_r   <= alc_pkg::SHUT_CEIL_RST;
			loop_priority_r     <= 1'b0;
			stats_window_one_r  <= {alc_pkg::WIN_OFS_RST, alc_pkg::WIN_LEN_RST,
				alc_pkg::WIN_OFS_RST, alc_pkg::WIN_LEN_RST};
			image_win_r         <= {alc_pkg::WIN_OFS_RST, alc_pkg::WIN_LEN_RST,
				alc_pkg::WIN_OFS_RST, alc_pkg::WIN_LEN_RST};
		end
		else if (wr_r)
		begin
			case (addr_r)
				alc_pkg::OFS_CTRL:       loop_priority_r <= hwdata[alc_pkg::CTRL_PRIO_BIT];
				alc_pkg::OFS_TARGET:     brightness_target_r <= hwdata[7:0]; // [R05]
				alc_pkg::OFS_AMP_LIM:
				begin
					amp_floor_r   <= hwdata[AW-1:0];
					amp_ceiling_r <= hwdata[alc_pkg::HI_LSB+AW-1:alc_pkg::HI_LSB];
				end
				alc_pkg::OFS_SHUT_FLOOR: shutter_floor_r <= hwdata[SW-1:0];
				alc_pkg::OFS_SHUT_CEIL:  shutter_ceiling_r <= hwdata[SW-1:0];
				alc_pkg::OFS_STATS_X:    stats_window_one_r[4*CW-1:2*CW] <= {hwdata[11:0], hwdata[27:16]};
				alc_pkg::OFS_STATS_Y:    stats_window_one_r[2*CW-1:0] <= {hwdata[11:0], hwdata[27:16]};
				alc_pkg::OFS_IMAGE_X:    image_win_r[4*CW-1:2*CW] <= {hwdata[11:0], hwdata[27:16]};
				alc_pkg::OFS_IMAGE_Y:    image_win_r[2*CW-1:0] <= {hwdata[11:0], hwdata[27:16]};
				default:                 ;
			endcase
		end
	end

	// ----------------------------------------
	// Gain loop
	// ----------------------------------------
	logic wr_ctrl;
	assign wr_ctrl = wr_r && (addr_r == alc_pkg::OFS_CTRL);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			amp_loop_mode_r <= alc_pkg::MODE_OFF;
			amp_manual_r    <= alc_pkg::AMP_MAN_RST;
			amp_now_r       <= alc_pkg::AMP_MAN_RST;
			amp_tries_r     <= '0;
		end
		else if (wr_r && addr_r == alc_pkg::OFS_AMP_MAN)
		begin
			amp_manual_r <= hwdata[AW-1:0];
			amp_now_r    <= hwdata[AW-1:0]; // [R16]
		end
		else if (wr_ctrl)
		begin
			// Software write wins over the hardware switch-off
			case (hwdata[alc_pkg::CTRL_AMP_LSB+:2])
				2'b01:   amp_loop_mode_r <= alc_pkg::MODE_ONCE;
				2'b10:   amp_loop_mode_r <= alc_pkg::MODE_CONT;
				default: amp_loop_mode_r <= alc_pkg::MODE_OFF;
			endcase
			amp_tries_r <= '0;
		end
		else if (done && amp_run)
		begin
			if (empty)
				amp_now_r <= amp_manual_r; // [R03]
			else if (amp_move)
				amp_now_r <= amp_step_val; // [R01]
			if (amp_loop_mode_r == alc_pkg::MODE_ONCE)
			begin
				amp_tries_r <= amp_tries_r + 5'h01;
				if ((!empty && !dark && !bright) ||
					amp_tries_r + 5'h01 >= alc_pkg::ONCE_MAX_FRAMES) // [R15]
					amp_loop_mode_r <= alc_pkg::MODE_OFF; // [R02] [R16]
			end
		end
	end

	// ----------------------------------------
	// Exposure loop
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			shutter_loop_mode_r <= alc_pkg::MODE_OFF;
			shutter_manual_r    <= alc_pkg::SHUT_MAN_RST;
			shutter_now_r       <= alc_pkg::SHUT_MAN_RST;
			shut_tries_r        <= '0;
		end
		else if (wr_r && addr_r == alc_pkg::OFS_SHUT_MAN)
		begin
			shutter_manual_r <= hwdata[SW-1:0];
			shutter_now_r    <= hwdata[SW-1:0]; // [R16]
		end
		else if (wr_ctrl)
		begin
			case (hwdata[alc_pkg::CTRL_SHUT_LSB+:2])
				2'b01:   shutter_loop_mode_r <= alc_pkg::MODE_ONCE;
				2'b10:   shutter_loop_mode_r <= alc_pkg::MODE_CONT;
				default: shutter_loop_mode_r <= alc_pkg::MODE_OFF;
			endcase
			shut_tries_r <= '0;
		end
		else if (done && shut_run)
		begin
			if (empty)
				shutter_now_r <= shutter_manual_r; // [R09]
			else if (shut_move)
				shutter_now_r <= shut_step_val; // [R07]
			if (shutter_loop_mode_r == alc_pkg::MODE_ONCE)
			begin
				shut_tries_r <= shut_tries_r + 5'h01;
				if ((!empty && !dark && !bright) ||
					shut_tries_r + 5'h01 >= alc_pkg::ONCE_MAX_FRAMES) // [R15]
					shutter_loop_mode_r <= alc_pkg::MODE_OFF;
			end
		end
	end

	// ----------------------------------------
	// Last frame result
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			last_dark_r   <= 1'b0;
			last_bright_r <= 1'b0;
			last_empty_r  <= 1'b0;
		end
		else if (done)
		begin
			last_dark_r   <= dark;
			last_bright_r <= bright;
			last_empty_r  <= empty;
		end
	end

endmodule : auto_luminance_control

// [sim/alc_sva.sv]
`timescale 1ns/10ps
module alc_sva
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        frame_end,
	input wire logic        pix_wide,
	input wire logic        binning_on,
	input wire logic        amp_limits_removed,
	input wire logic [11:0] amp_now_r,
	input wire logic [23:0] shutter_now_r
);
	// ----------------
	// Bus phase trackers
	// ----------------
	logic       rd_r;
	logic       wr_r;
	logic [7:0] wa_r;
	wire        take = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) rd_r <= 1'b0; else rd_r <= take && !hwrite;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) wr_r <= 1'b0; else wr_r <= take && hwrite;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) wa_r <= 8'h00; else wa_r <= haddr[7:0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	write_zero_a: assert property (take && hwrite |=> hreadyout) else $error("write waited");
	ready_idle_a: assert property (hreadyout == !rd_r) else $error("hreadyout wrong");
	rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_r)) else $error("hrdata moved");
	// Loop values move only at a frame decision or a manual write
	amp_hold_a: assert property ($changed(amp_now_r) |-> $past(frame_end, 2) ||
		($past(wr_r) && $past(wa_r) == alc_pkg::OFS_AMP_MAN)) else $error("gain moved");
	shut_hold_a: assert property ($changed(shutter_now_r) |-> $past(frame_end, 2) ||
		($past(wr_r) && $past(wa_r) == alc_pkg::OFS_SHUT_MAN)) else $error("exposure moved");
	amp_bound_a: assert property ($changed(amp_now_r) && $past(frame_end, 2) |->
		amp_now_r <= (amp_limits_removed ? alc_pkg::AMP_MAX_EXT : alc_pkg::AMP_MAX_STD) &&
		amp_now_r >= (binning_on ? alc_pkg::AMP_MIN_BIN :
		pix_wide ? alc_pkg::AMP_MIN_WIDE : alc_pkg::AMP_MIN_NARROW)) else $error("gain bound");
	shut_bound_a: assert property ($changed(shutter_now_r) && $past(frame_end, 2)
		|-> shutter_now_r >= alc_pkg::SHUT_MIN && shutter_now_r <= alc_pkg::SHUT_MAX)
		else $error("exposure bound");
endmodule : alc_sva
bind auto_luminance_control alc_sva chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hrdata, .hresp, .frame_end, .pix_wide, .binning_on,
	.amp_limits_removed, .amp_now_r, .shutter_now_r);

// [sim/auto_luminance_control_test.sv]
`timescale 1ns/10ps
module auto_luminance_control_test;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic        frame_start = 1'b0, frame_end = 1'b0, pix_valid = 1'b0;
	logic        pix_wide = 1'b0, trigger_width_mode = 1'b0;
	logic        binning_on = 1'b0, amp_limits_removed = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [11:0] pix_x = 12'h000, pix_data = 12'h000, amp_now_r, ea;
	logic [23:0] shutter_now_r;
	logic [7:0]  r;
	int          mismatches = 0, cmp_count = 0, cyc = 0, seed = 87;
	localparam logic [11:0] dk = 12'h010;
	localparam logic [23:0] sh = alc_pkg::SHUT_MAN_RST;
	always #10 hclk = ~hclk;
	auto_luminance_control uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.frame_start, .frame_end, .pix_valid, .pix_x, .pix_y(12'h000), .pix_data,
		.pix_wide, .binning_on, .amp_limits_removed, .trigger_width_mode,
		.amp_now_r, .shutter_now_r);
	// ----------------
	// Helpers
	// ----------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task frame(input logic [11:0] a, input logic [11:0] b);
		@(posedge hclk) frame_start <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge hclk);
			frame_start <= 1'b0;
			pix_valid <= 1'b1;
			pix_x <= 12'(i);
			pix_data <= (i < 8) ? a : b;
		end
		@(posedge hclk);
		pix_valid <= 1'b0;
		frame_end <= 1'b1;
		@(posedge hclk) frame_end <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : frame
	task step(input logic [11:0] a, input logic [11:0] b, input logic [11:0] g,
		input logic [23:0] s);
		frame(a, b);
		chk(32'(amp_now_r), 32'(g));
		chk(32'(shutter_now_r), 32'(s));
	endtask : step
	function logic [11:0] up(input logic [11:0] c);
		return (c + alc_pkg::AMP_STEP > 12'h048) ? 12'h048 : c + alc_pkg::AMP_STEP;
	endfunction : up
	function logic [11:0] dark();
		return 12'($random(seed)) & 12'h03F;
	endfunction : dark
	task give_verdict;
		$display("mismatches=%0d compares=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			give_verdict;
		end
	end
	// ----------------
	// Sequence
	// ----------------
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		r = 8'($random(seed)) | 8'h80;
		bus(1'b0, alc_pkg::OFS_TARGET, 32'h0);
		chk(rd, 32'h00000080);
		bus(1'b0, alc_pkg::OFS_AMP_LIM, 32'h0);
		chk(rd, 32'h0FFF0000);
		bus(1'b0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, alc_pkg::OFS_TARGET, 32'(r));
		bus(1'b0, alc_pkg::OFS_TARGET, 32'h0);
		chk(rd, 32'(r));
		$display("test regs done");
		bus(1'b1, alc_pkg::OFS_AMP_LIM, 32'h00480040);
		bus(1'b1, alc_pkg::OFS_CTRL, 32'h2);
		pix_wide <= 1'b1;
		step({r, 4'h0}, {r, 4'h0}, 12'h040, sh);
		pix_wide <= 1'b0;
		bus(1'b1, alc_pkg::OFS_STATS_X, 32'h00080000);
		step(12'(r), 12'h000, 12'h040, sh);
		bus(1'b1, alc_pkg::OFS_STATS_X, 32'h0FFF0000);
		ea = 12'h040;
		repeat (3)
		begin
			ea = up(ea);
			step(dark(), dark(), ea, sh);
		end
		$display("test gain done");
		bus(1'b1, alc_pkg::OFS_CTRL, 32'h1);
		repeat (29) frame(dk, dk);
		bus(1'b0, alc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h1);
		frame(dk, dk);
		bus(1'b0, alc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'h0);
		chk(32'(amp_now_r), 32'h048);
		bus(1'b1, alc_pkg::OFS_AMP_MAN, 32'h44);
		step(dk, dk, 12'h044, sh);
		$display("test once done");
		bus(1'b1, alc_pkg::OFS_CTRL, 32'h2);
		step(dk, dk, 12'h048, sh);
		bus(1'b1, alc_pkg::OFS_STATS_X, 32'h00100100);
		bus(1'b1, alc_pkg::OFS_IMAGE_X, 32'h00100000);
		step(dk, dk, 12'h044, sh);
		bus(1'b0, alc_pkg::OFS_STATUS, 32'h0);
		chk(32'(rd[4]), 32'h1);
		bus(1'b1, alc_pkg::OFS_STATS_X, 32'h0FFF0000);
		$display("test overlap done");
		bus(1'b1, alc_pkg::OFS_CTRL, 32'h8);
		trigger_width_mode <= 1'b1;
		step(dk, dk, 12'h044, sh);
		trigger_width_mode <= 1'b0;
		bus(1'b1, alc_pkg::OFS_SHUT_MAN, 32'h2713);
		step(dk, dk, 12'h044, 24'h002723);
		bus(1'b1, alc_pkg::OFS_SHUT_CEIL, 32'h2730);
		step(dk, dk, 12'h044, 24'h002730);
		bus(1'b1, alc_pkg::OFS_SHUT_CEIL, 32'hFFFFFF);
		bus(1'b1, alc_pkg::OFS_SHUT_MAN, 32'(alc_pkg::SHUT_MAX - 24'h8));
		step(dk, dk, 12'h044, alc_pkg::SHUT_MAX);
		$display("test shutter done");
		bus(1'b1, alc_pkg::OFS_SHUT_MAN, 32'(sh));
		bus(1'b1, alc_pkg::OFS_CTRL, 32'hA);
		step(dk, dk, 12'h044, 24'h002720);
		bus(1'b1, alc_pkg::OFS_CTRL, 32'h1A);
		step(dk, dk, 12'h048, 24'h002720);
		amp_limits_removed <= 1'b1;
		bus(1'b1, alc_pkg::OFS_AMP_LIM, 32'h0FFF0000);
		bus(1'b1, alc_pkg::OFS_AMP_MAN, 32'h3FE);
		step(dk, dk, 12'h402, 24'h002720);
		$display("test priority done");
		give_verdict;
	end
endmodule : auto_luminance_control_test
